// ### hdl/brf_pkg.sv
// Shared constants, register map and carrier types for the block memory FIFO
package brf_pkg;
    localparam int BRF_DATA_W = 18;
    localparam int BRF_ADDR_W = 10;
    localparam int BRF_PTR_W = BRF_ADDR_W + 1;
    localparam int BRF_DEPTH = 1 << BRF_ADDR_W;
    localparam int BRF_EVT_W = 6;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] BRF_OFS_CTRL = 8'h00;
    localparam logic [7:0] BRF_OFS_FULL_LVL = 8'h04;
    localparam logic [7:0] BRF_OFS_AFULL_LVL = 8'h08;
    localparam logic [7:0] BRF_OFS_AEMPTY_LVL = 8'h0c;
    localparam logic [7:0] BRF_OFS_STATUS = 8'h10;
    localparam logic [7:0] BRF_OFS_INT_STAT = 8'h14;
    localparam logic [7:0] BRF_OFS_INT_MASK = 8'h18;

    // -------------------------------------------------------------------
    // Control fields
    // -------------------------------------------------------------------
    localparam int BRF_CTRL_FIFO = 0;
    localparam int BRF_CTRL_MODE_LO = 1;
    localparam int BRF_CTRL_ASYNC = 3;
    localparam int BRF_CTRL_CLEAR = 8;
    localparam int BRF_CTRL_REWIND = 9;

    // Event bits, shared by interrupt status and mask
    localparam int BRF_EV_FULL = 0;
    localparam int BRF_EV_AFULL = 1;
    localparam int BRF_EV_EMPTY = 2;
    localparam int BRF_EV_AEMPTY = 3;
    localparam int BRF_EV_OVER = 4;
    localparam int BRF_EV_UNDER = 5;

    // Reset values of the programmable levels; empty level is fixed at zero
    localparam logic [BRF_PTR_W-1:0] BRF_FULL_RST = BRF_PTR_W'(BRF_DEPTH - 1);
    localparam logic [BRF_PTR_W-1:0] BRF_AFULL_RST = BRF_PTR_W'(BRF_DEPTH - 2);
    localparam logic [BRF_PTR_W-1:0] BRF_AEMPTY_RST = 11'h001;
    localparam logic [BRF_PTR_W-1:0] BRF_LVL_MIN = 11'h001;
    localparam logic [BRF_PTR_W-1:0] BRF_EMPTY_LVL = 11'h000;

    typedef enum logic [1:0] {
        BRF_WR_NORMAL,
        BRF_WR_THROUGH,
        BRF_WR_READ_FIRST
    } brf_wmode_type;

    // Write side / port A
    typedef struct packed {
        logic [BRF_ADDR_W-1:0] addr;
        logic [BRF_DATA_W-1:0] data;
        logic writeClockEnable;
        logic writeStrobe;
        logic writeClock;
    } brf_wport_type;

    // Read side / port B
    typedef struct packed {
        logic [BRF_ADDR_W-1:0] addr;
        logic readClockEnable;
        logic readStrobe;
        logic readClock;
    } brf_rport_type;

    typedef struct packed {
        logic full;
        logic almostFull;
        logic empty;
        logic almostEmpty;
    } brf_flags_type;
endpackage : brf_pkg

// ### hdl/brf_block_fifo.sv
// Block memory with port A write modes, FIFO mode and output latch clears
//
// Contract
// RULE1 - Normal write leaves port output unchanged
// RULE2 - Write-through copies written word to output
// RULE3 - Read-before-write outputs old location contents
// RULE4 - FIFO has independent write and read ports
// RULE5 - Full and almost-full registered on write clock
// RULE6 - Empty and almost-empty registered on read clock
// RULE7 - Thresholds programmable in ranges, empty fixed zero
// RULE8 - Global clear resets pointers and all flags
// RULE9 - Rewind resets read pointer only
// RULE10 - Output latch clear selectable sync or async
// RULE11 - Separate latch clears for ports A, B
// RULE12 - Chip-wide reset clears both output latches
// RULE13 - Writes when full, reads when empty ignored
// RULE14 - User tracks packet boundaries before rewinding
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module brf_block_fifo
    import brf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chipWideResetN,
    input wire logic portALatchClear,
    input wire logic portBLatchClear,
    input wire brf_wport_type writePort,
    input wire brf_rport_type readPort,
    output logic [BRF_DATA_W-1:0] dataOutA,
    output logic [BRF_DATA_W-1:0] dataOutB,
    output brf_flags_type flags,
    output logic irq,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // -------------------------------------------------------------------
    // Register bus slave
    // -------------------------------------------------------------------
    logic [31:0] ctrl;
    logic [BRF_PTR_W-1:0] fullLevel;
    logic [BRF_PTR_W-1:0] afullLevel;
    logic [BRF_PTR_W-1:0] aemptyLevel;
    logic [BRF_EVT_W-1:0] intStatus;
    logic [BRF_EVT_W-1:0] intMask;
    logic wrPending;
    logic [7:0] wrAddr;
    logic accept;
    logic [BRF_PTR_W-1:0] wrPtr;
    logic [BRF_PTR_W-1:0] rdPtr;
    logic [BRF_PTR_W-1:0] level;
    logic fifoClear;
    logic rewind;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign accept = hsel & htrans[1] & hready;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            wrPending <= accept & hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // Clamp a written level into 1 .. top
    function automatic logic [BRF_PTR_W-1:0] clampLevel(
        input logic [31:0] value,
        input logic [BRF_PTR_W-1:0] top
    );
        logic [BRF_PTR_W-1:0] v;
        v = value[BRF_PTR_W-1:0];
        if (value[31:BRF_PTR_W] != '0 || v > top) begin
            v = top;
        end else if (v < BRF_LVL_MIN) begin
            v = BRF_LVL_MIN;
        end
        return v;
    endfunction : clampLevel

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl <= 32'h0000_0000;
            fullLevel <= BRF_FULL_RST;
            afullLevel <= BRF_AFULL_RST;
            aemptyLevel <= BRF_AEMPTY_RST;
            intMask <= '0;
        end else begin
            ctrl[BRF_CTRL_CLEAR] <= 1'b0;
            ctrl[BRF_CTRL_REWIND] <= 1'b0;
            if (wrPending) begin
                case (wrAddr)
                    BRF_OFS_CTRL: ctrl <= hwdata;
                    BRF_OFS_FULL_LVL: // [RULE7]
                        fullLevel <= clampLevel(hwdata,
                            BRF_PTR_W'(BRF_DEPTH - 1));
                    BRF_OFS_AFULL_LVL: // [RULE7]
                        afullLevel <= clampLevel(hwdata,
                            fullLevel - BRF_LVL_MIN);
                    BRF_OFS_AEMPTY_LVL: // [RULE7]
                        aemptyLevel <= clampLevel(hwdata,
                            fullLevel - BRF_LVL_MIN);
                    BRF_OFS_INT_MASK: intMask <= hwdata[BRF_EVT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    assign fifoClear = ctrl[BRF_CTRL_CLEAR];
    assign rewind = ctrl[BRF_CTRL_REWIND];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            case (haddr[7:0])
                BRF_OFS_CTRL: hrdata <= ctrl;
                BRF_OFS_FULL_LVL: hrdata <= 32'(fullLevel);
                BRF_OFS_AFULL_LVL: hrdata <= 32'(afullLevel);
                BRF_OFS_AEMPTY_LVL: hrdata <= 32'(aemptyLevel);
                BRF_OFS_STATUS: hrdata <= {5'h00, level, 12'h000, flags};
                BRF_OFS_INT_STAT: hrdata <= 32'(intStatus);
                BRF_OFS_INT_MASK: hrdata <= 32'(intMask);
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Memory and port operations
    // -------------------------------------------------------------------
    logic [BRF_DATA_W-1:0] memory [BRF_DEPTH];
    logic fifoMode;
    brf_wmode_type writeMode;
    logic tickA;
    logic tickB;
    logic doWrite;
    logic doRead;
    logic [BRF_ADDR_W-1:0] writeAddr;
    logic [BRF_ADDR_W-1:0] readAddr;
    logic [BRF_DATA_W-1:0] memAtA;

    assign fifoMode = ctrl[BRF_CTRL_FIFO];
    assign writeMode = brf_wmode_type'(ctrl[BRF_CTRL_MODE_LO +: 2]);
    // Both sides clocked by their own clock and clock-enable inputs as enables [RULE4]
    assign tickA = writePort.writeClock & writePort.writeClockEnable;
    assign tickB = readPort.readClock & readPort.readClockEnable;
    assign doWrite = tickA & writePort.writeStrobe
        & ~(fifoMode & flags.full); // [RULE13]
    assign doRead = tickB & readPort.readStrobe & ~flags.empty; // [RULE13]
    assign writeAddr = fifoMode ? wrPtr[BRF_ADDR_W-1:0] : writePort.addr;
    assign readAddr = fifoMode ? rdPtr[BRF_ADDR_W-1:0] : readPort.addr;
    assign memAtA = memory[writePort.addr];

    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            memory[writeAddr] <= writePort.data;
        end
    end

    // -------------------------------------------------------------------
    // Output latches
    // -------------------------------------------------------------------
    logic latchAsync;
    logic latchResetA;
    logic latchResetB;

    assign latchAsync = ctrl[BRF_CTRL_ASYNC];
    assign latchResetA = rst | ~chipWideResetN
        | (portALatchClear & latchAsync); // [RULE10] [RULE11] [RULE12]
    assign latchResetB = rst | ~chipWideResetN
        | (portBLatchClear & latchAsync); // [RULE10] [RULE11] [RULE12]

    always_ff @(posedge core_clk or posedge latchResetA) begin
        if (latchResetA) begin
            dataOutA <= '0;
        end else if (portALatchClear) begin
            dataOutA <= '0; // [RULE10]
        end else if (tickA && !fifoMode) begin
            if (!writePort.writeStrobe) begin
                dataOutA <= memAtA;
            end else if (writeMode == BRF_WR_THROUGH) begin
                dataOutA <= writePort.data; // [RULE2]
            end else if (writeMode == BRF_WR_READ_FIRST) begin
                dataOutA <= memAtA; // [RULE3]
            end // Normal write holds the output [RULE1]
        end
    end

    always_ff @(posedge core_clk or posedge latchResetB) begin
        if (latchResetB) begin
            dataOutB <= '0;
        end else if (portBLatchClear) begin
            dataOutB <= '0; // [RULE10]
        end else if (fifoMode ? doRead : tickB) begin
            dataOutB <= memory[readAddr];
        end
    end

    // -------------------------------------------------------------------
    // FIFO pointers and flags
    // -------------------------------------------------------------------
    logic [BRF_PTR_W-1:0] next_wrPtr;
    logic [BRF_PTR_W-1:0] next_rdPtr;
    logic [BRF_PTR_W-1:0] writeSideLevel;
    logic [BRF_PTR_W-1:0] readSideLevel;
    logic fullFlag;
    logic almostFullFlag;
    logic emptyFlag;
    logic almostEmptyFlag;

    // One driver for the flag word, two flag halves on separate sides
    assign flags = '{full: fullFlag, almostFull: almostFullFlag,
        empty: emptyFlag, almostEmpty: almostEmptyFlag};

    assign next_wrPtr = wrPtr + BRF_PTR_W'(doWrite & fifoMode);
    assign next_rdPtr = rewind ? '0 : rdPtr + BRF_PTR_W'(doRead & fifoMode);
    assign writeSideLevel = next_wrPtr - next_rdPtr;
    assign readSideLevel = wrPtr - next_rdPtr;
    assign level = wrPtr - rdPtr;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else if (fifoClear) begin
            wrPtr <= '0; // [RULE8]
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr; // [RULE9]
            rdPtr <= next_rdPtr; // [RULE9]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fullFlag <= 1'b0;
            almostFullFlag <= 1'b0;
        end else if (fifoClear) begin
            fullFlag <= 1'b0; // [RULE8]
            almostFullFlag <= 1'b0;
        end else if (tickA || rewind) begin
            fullFlag <= writeSideLevel >= fullLevel; // [RULE5]
            almostFullFlag <= writeSideLevel >= afullLevel; // [RULE5]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            emptyFlag <= 1'b1;
            almostEmptyFlag <= 1'b1;
        end else if (fifoClear) begin
            emptyFlag <= 1'b1; // [RULE8]
            almostEmptyFlag <= 1'b1;
        end else if (tickB || rewind) begin
            emptyFlag <= readSideLevel == BRF_EMPTY_LVL; // [RULE6]
            almostEmptyFlag <= readSideLevel <= aemptyLevel; // [RULE6]
        end
    end

    // -------------------------------------------------------------------
    // Interrupts
    // -------------------------------------------------------------------
    logic [BRF_EVT_W-1:0] events;
    logic [BRF_EVT_W-1:0] clearMask;

    always_comb begin
        events = '0;
        events[BRF_EV_FULL] = tickA & ~flags.full
            & (writeSideLevel >= fullLevel);
        events[BRF_EV_AFULL] = tickA & ~flags.almostFull
            & (writeSideLevel >= afullLevel);
        events[BRF_EV_EMPTY] = tickB & ~flags.empty
            & (readSideLevel == BRF_EMPTY_LVL);
        events[BRF_EV_AEMPTY] = tickB & ~flags.almostEmpty
            & (readSideLevel <= aemptyLevel);
        events[BRF_EV_OVER] = fifoMode & tickA & writePort.writeStrobe
            & flags.full;
        events[BRF_EV_UNDER] = fifoMode & tickB & readPort.readStrobe
            & flags.empty;
        if (!fifoMode || fifoClear) begin
            events = '0;
        end
    end

    assign clearMask = (wrPending && wrAddr == BRF_OFS_INT_STAT)
        ? hwdata[BRF_EVT_W-1:0] : '0;

    // Set wins over a same-cycle write-one-to-clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intStatus <= '0;
        end else begin
            intStatus <= (intStatus & ~clearMask) | events;
        end
    end

    assign irq = |(intStatus & intMask);

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence ramWriteA(brf_wmode_type m);
        tickA && !fifoMode && writePort.writeStrobe && writeMode == m
            && !portALatchClear && chipWideResetN;
    endsequence

    a_normal_hold: assert property ( // [RULE1]
        ramWriteA(BRF_WR_NORMAL) |=> $stable(dataOutA))
        else $error("Normal write changed port A output");
    a_write_through: assert property ( // [RULE2]
        ramWriteA(BRF_WR_THROUGH) |=> dataOutA == $past(writePort.data))
        else $error("Write-through word missing on port A");
    a_read_first: assert property ( // [RULE3]
        ramWriteA(BRF_WR_READ_FIRST) |=> dataOutA == $past(memAtA))
        else $error("Read-before-write did not show old word");
    a_full_ignored: assert property ( // [RULE13]
        fifoMode && flags.full && !fifoClear |=> wrPtr == $past(wrPtr))
        else $error("Write pointer moved while full");
    a_empty_ignored: assert property ( // [RULE13]
        fifoMode && flags.empty && !fifoClear && !rewind
        |=> rdPtr == $past(rdPtr))
        else $error("Read pointer moved while empty");
    a_clear_resets_all: assert property ( // [RULE8]
        fifoClear |=> wrPtr == '0 && rdPtr == '0 && flags.empty
            && !flags.full && flags.almostEmpty && !flags.almostFull)
        else $error("Global clear left pointers or flags");
    a_rewind_keeps_write: assert property ( // [RULE9]
        rewind && !fifoClear && !doWrite
        |=> rdPtr == '0 && wrPtr == $past(wrPtr))
        else $error("Rewind disturbed write side");
    a_full_on_write_tick: assert property ( // [RULE5]
        !tickA && !rewind && !fifoClear |=> $stable(flags.full))
        else $error("Full flag changed without write clock");
    a_empty_on_read_tick: assert property ( // [RULE6]
        !tickB && !rewind && !fifoClear |=> $stable(flags.empty))
        else $error("Empty flag changed without read clock");
    a_latch_clear_b: assert property ( // [RULE11]
        portBLatchClear ##1 portBLatchClear |-> dataOutB == '0)
        else $error("Port B latch not cleared");
    a_level_range: assert property ( // [RULE7]
        afullLevel >= BRF_LVL_MIN && afullLevel < BRF_PTR_W'(BRF_DEPTH))
        else $error("Almost-full level out of range");
endmodule : brf_block_fifo

// ### verification/brf_fabric_model.sv
// Fabric-side user logic driving the FIFO write and read ports
`timescale 1ns/100ps
module brf_fabric_model
    import brf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wrTick,
    input wire logic rdTick,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [BRF_ADDR_W-1:0] addrA,
    input wire logic [BRF_ADDR_W-1:0] addrB,
    input wire logic [BRF_DATA_W-1:0] wrData,
    output brf_wport_type writePort,
    output brf_rport_type readPort
);
    logic [BRF_DATA_W-1:0] lastData;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lastData <= '0;
        end else if (wrTick) begin
            lastData <= wrData;
        end
    end

    // Outside a tick the data lines never show the last word
    assign writePort = '{addrA, wrTick ? wrData : ~lastData, wrTick,
        wrStrobe & wrTick, wrTick};
    assign readPort = '{addrB, rdTick, rdStrobe & rdTick, rdTick};
endmodule : brf_fabric_model

// ### verification/tb_top.sv
// Self-checking testbench for the block memory FIFO
`timescale 1ns/100ps
module tb_top
    import brf_pkg::*;
;
    logic core_clk = 0, rst = 1, chipWideResetN = 1;
    logic [1:0] clr = '0;
    logic wrTick = 0, rdTick = 0, wrStrobe = 0, rdStrobe = 0;
    logic [9:0] addrA = '0, addrB = '0;
    logic [17:0] wrData = '0, dataOutA, dataOutB;
    brf_wport_type writePort;
    brf_rport_type readPort;
    brf_flags_type flags;
    logic irq, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'h33;
    logic [17:0] mem [6];
    logic [17:0] q [$];
    int bad_count = 0, comparisons = 0;

    always #2.5 core_clk = ~core_clk;

    brf_fabric_model fab_u (.core_clk(core_clk), .rst(rst), .wrTick(wrTick),
        .rdTick(rdTick), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .addrA(addrA), .addrB(addrB), .wrData(wrData),
        .writePort(writePort), .readPort(readPort));

    brf_block_fifo dut_u (.core_clk(core_clk), .rst(rst),
        .chipWideResetN(chipWideResetN), .portALatchClear(clr[0]),
        .portBLatchClear(clr[1]), .writePort(writePort),
        .readPort(readPort), .dataOutA(dataOutA), .dataOutB(dataOutB),
        .flags(flags), .irq(irq), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic brf_flags_type exp_flags(int lvl, int fl, int af,
        int ae);
        return '{lvl >= fl, lvl >= af, lvl == 0, lvl <= ae};
    endfunction : exp_flags

    function automatic logic [17:0] exp_mode(int m, logic [17:0] o,
        logic [17:0] p, logic [17:0] d);
        return (m == 0) ? p : (m == 1) ? d : o;
    endfunction : exp_mode

    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk_word

    task automatic chk_flags(string n, brf_flags_type e, brf_flags_type g);
        comparisons++;
        if (g !== e) begin
            $display("FAIL %s expected %b seen %b", n, e, g);
            bad_count++;
        end
    endtask : chk_flags

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            bad_count++;
            wrap_up();
        end
    endtask : wait_ready

    task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        #1;
    endtask : ahb

    task automatic op(logic wt, logic rt, logic ws, logic rs,
        logic [9:0] aa, logic [9:0] ab, logic [17:0] d);
        @(posedge core_clk);
        wrTick <= wt;
        rdTick <= rt;
        wrStrobe <= ws;
        rdStrobe <= rs;
        addrA <= aa;
        addrB <= ab;
        wrData <= d;
        @(posedge core_clk);
        wrTick <= 0;
        rdTick <= 0;
        #1;
    endtask : op

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        logic [7:0] tOfs [6];
        int tIn [6], tExp [6];
        logic [17:0] o, p, d;
        tOfs = '{BRF_OFS_FULL_LVL, BRF_OFS_FULL_LVL, BRF_OFS_FULL_LVL,
            BRF_OFS_AFULL_LVL, BRF_OFS_AEMPTY_LVL, BRF_OFS_AEMPTY_LVL};
        tIn = '{0, 2047, 4, 9, 0, 2};
        tExp = '{1, 1023, 4, 3, 1, 2};
        repeat (10) @(posedge core_clk);
        rst <= 0;
        #1;
        chk_flags("reset flags", 4'b0011, flags);
        chk_word("reset irq", 32'h0, {31'h0, irq});
        chk_word("okay resp", 32'h0, {31'h0, hresp});
        ahb(0, BRF_OFS_FULL_LVL, 0);
        chk_word("full lvl", 32'(BRF_FULL_RST), rd);
        ahb(0, BRF_OFS_AFULL_LVL, 0);
        chk_word("afull lvl", 32'(BRF_AFULL_RST), rd);
        ahb(0, BRF_OFS_AEMPTY_LVL, 0);
        chk_word("aempty lvl", 32'(BRF_AEMPTY_RST), rd);
        ahb(0, 8'h1c, 0);
        chk_word("unmapped", 32'h0, rd);
        for (int m = 0; m < 3; m++) begin
            o = 18'(rnd());
            p = 18'(rnd());
            d = 18'(rnd());
            // Fill both words first so read-before-write never shows junk
            op(1, 0, 1, 0, 10'(2 * m), 0, o);
            op(1, 0, 1, 0, 10'(2 * m + 1), 0, p);
            ahb(1, BRF_OFS_CTRL, 32'(m) << BRF_CTRL_MODE_LO);
            op(1, 0, 0, 0, 10'(2 * m + 1), 0, 0);
            chk_word("read A", 32'(p), 32'(dataOutA));
            op(1, 0, 1, 0, 10'(2 * m), 0, d);
            chk_word("write A", 32'(exp_mode(m, o, p, d)),
                32'(dataOutA));
            op(0, 1, 0, 0, 0, 10'(2 * m), 0);
            chk_word("read B", 32'(d), 32'(dataOutB));
            mem[2 * m] = d;
            mem[2 * m + 1] = p;
        end
        for (int k = 0; k < 4; k++) begin
            ahb(1, BRF_OFS_CTRL, 32'(k / 2) << BRF_CTRL_ASYNC);
            op(1, 1, 0, 0, 10'd5, 10'd4, 0);
            @(posedge core_clk);
            clr[k % 2] <= 1;
            #1;
            chk_word("clr A now", (k == 2) ? 0 : 32'(mem[5]),
                32'(dataOutA));
            chk_word("clr B now", (k == 3) ? 0 : 32'(mem[4]),
                32'(dataOutB));
            @(posedge core_clk);
            #1;
            chk_word("clr A edge", (k % 2 == 0) ? 0 : 32'(mem[5]),
                32'(dataOutA));
            chk_word("clr B edge", (k % 2 == 1) ? 0 : 32'(mem[4]),
                32'(dataOutB));
            @(posedge core_clk);
            clr <= '0;
        end
        op(1, 1, 0, 0, 10'd5, 10'd4, 0);
        @(posedge core_clk);
        chipWideResetN <= 0;
        #1;
        chk_word("chip rst A", 0, 32'(dataOutA));
        chk_word("chip rst B", 0, 32'(dataOutB));
        @(posedge core_clk);
        chipWideResetN <= 1;
        ahb(1, BRF_OFS_CTRL, 32'h1);
        for (int i = 0; i < 6; i++) begin
            ahb(1, tOfs[i], 32'(tIn[i]));
            ahb(0, tOfs[i], 0);
            chk_word("level clamp", 32'(tExp[i]), rd);
        end
        for (int i = 0; i < 5; i++) begin
            d = 18'(rnd());
            if (i < 4) begin
                q.push_back(d);
            end
            op(1, 0, 1, 0, 0, 0, d);
        end
        chk_flags("write side", 4'b1111, flags);
        op(0, 1, 0, 0, 0, 0, 0);
        chk_flags("read side", exp_flags(4, 4, 3, 2), flags);
        ahb(0, BRF_OFS_STATUS, 0);
        chk_word("fill full", 32'h4, {21'h0, rd[26:16]});
        ahb(0, BRF_OFS_INT_STAT, 0);
        chk_word("overflow", 32'h1, 32'(rd[BRF_EV_OVER]));
        chk_word("irq masked", 32'h0, {31'h0, irq});
        ahb(1, BRF_OFS_INT_MASK, 32'h1 << BRF_EV_OVER);
        chk_word("irq on", 32'h1, {31'h0, irq});
        ahb(1, BRF_OFS_INT_STAT, 32'h1 << BRF_EV_OVER);
        chk_word("irq off", 32'h0, {31'h0, irq});
        for (int i = 0; i < 4; i++) begin
            op(0, 1, 0, 1, 0, 0, 0);
            chk_word("fifo data", 32'(q[i]), 32'(dataOutB));
        end
        op(0, 1, 0, 1, 0, 0, 0);
        chk_word("empty read", 32'(q[3]), 32'(dataOutB));
        // Full side only refreshes on a write tick or a rewind
        op(1, 0, 0, 0, 0, 0, 0);
        chk_flags("drained", exp_flags(0, 4, 3, 2), flags);
        ahb(0, BRF_OFS_INT_STAT, 0);
        chk_word("underflow", 32'h1, 32'(rd[BRF_EV_UNDER]));
        // Whole packet consumed, so it may be sent again
        ahb(1, BRF_OFS_CTRL, 32'h201);
        for (int i = 0; i < 4; i++) begin
            op(0, 1, 0, 1, 0, 0, 0);
            chk_word("resent", 32'(q[i]), 32'(dataOutB));
        end
        ahb(1, BRF_OFS_CTRL, 32'h101);
        @(posedge core_clk);
        #1;
        chk_flags("cleared", 4'b0011, flags);
        ahb(0, BRF_OFS_STATUS, 0);
        chk_word("fill clear", 32'h0, {21'h0, rd[26:16]});
        wrap_up();
    end
endmodule : tb_top
